// ==== togd_core.sv ====
// Time-out guard: control register, timed change window and counter.
// Assumes a plain register port and a one-cycle guard oscillator tick.
//
// How it works
// - Select field picks time-out of 16384 ticks doubled per step.
// - Level 0 lets any write change the time-out select field.
// - Level 1 starts disabled; a plain write of one enables it.
// - Level 1 accepts select change or disable only inside timed window.
// - Level 2 keeps the guard enabled and enable reads as one.
// - Change-enable clears itself four cycles after being set.
// - Two fuses fix the level; enabling is always allowed.
// - Counter clears on restart, while disabled and on reset.
// - Elapsed time-out without restart raises a chip reset.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module togd_core #(
  parameter int BASE_TICKS = togd_pkg::BASE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_compat_fuse,
  input wire logic i_always_on_fuse,
  input wire logic i_restart,
  input wire logic i_osc_tick,
  output logic o_chip_reset
);

  // ****************************************************************
  // Fuse capture and safety level
  // ****************************************************************
  logic fuse_ok_ff;
  logic compat_ff;
  logic always_on_ff;
  togd_pkg::togd_level_type level;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fuse_ok_ff <= 1'b0;
      compat_ff <= 1'b0;
      always_on_ff <= 1'b0;
    end
    else if (!fuse_ok_ff)
    begin
      fuse_ok_ff <= 1'b1;
      compat_ff <= i_compat_fuse;
      always_on_ff <= i_always_on_fuse;
    end
  end

  // Always-on fuse dominates the compatibility fuse
  assign level = always_on_ff ? togd_pkg::LVL2 :
                 compat_ff ? togd_pkg::LVL0 :
                 togd_pkg::LVL1;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wr_hit;
  logic rd_hit;
  logic open_wr;
  logic close_wr;
  logic win_open;
  logic lvl0;
  logic lvl2;

  assign wr_hit = i_wr && (i_addr == togd_pkg::CTRL_ADDR);
  assign rd_hit = i_rd && (i_addr == togd_pkg::CTRL_ADDR);
  assign open_wr = wr_hit && i_wdata[togd_pkg::CE_BIT]
                   && i_wdata[togd_pkg::EN_BIT];
  assign close_wr = wr_hit && !open_wr;
  assign lvl0 = (level == togd_pkg::LVL0);
  assign lvl2 = (level == togd_pkg::LVL2);

  // Window closes early on any control register write that does not reopen it
  togd_win #(
    .CYCLES(togd_pkg::CE_CYCLES)
  ) u_win (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(open_wr),
    .i_stop(close_wr),
    .o_open(win_open)
  );

  // ****************************************************************
  // Enable and time-out select
  // ****************************************************************
  logic en_ff;
  logic [2:0] sel_ff;
  logic nxt_en;
  logic [2:0] nxt_sel;
  logic en_eff;
  logic sel_ok;
  logic dis_ok;

  // Level 0 rewrites select freely, others only in the window
  assign sel_ok = lvl0 || win_open;
  // Disable needs the window and is impossible at level 2
  assign dis_ok = win_open && !lvl2;
  assign nxt_sel = (wr_hit && sel_ok) ?
                   i_wdata[togd_pkg::SEL_MSB:0] : sel_ff;
  assign nxt_en = lvl2 ? 1'b1 :
                  !wr_hit ? en_ff :
                  i_wdata[togd_pkg::EN_BIT] ? 1'b1 :
                  dis_ok ? 1'b0 : en_ff;
  assign en_eff = en_ff || lvl2;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      en_ff <= togd_pkg::EN_RESET;
      sel_ff <= togd_pkg::SEL_RESET;
    end
    else
    begin
      en_ff <= nxt_en;
      sel_ff <= nxt_sel;
    end
  end

  // ****************************************************************
  // Time-out counter
  // ****************************************************************
  logic [togd_pkg::CNT_W-1:0] cnt_ff;
  logic [togd_pkg::CNT_W-1:0] nxt_cnt;
  logic [togd_pkg::CNT_W-1:0] tmo_limit;
  logic tmo_hit;
  logic cnt_clr;
  logic chip_reset_ff;

  assign tmo_limit = togd_pkg::CNT_W'(BASE_TICKS) << sel_ff;
  assign tmo_hit = en_eff && i_osc_tick
                   && (cnt_ff == tmo_limit - togd_pkg::CNT_W'(1));
  assign cnt_clr = !en_eff || i_restart || tmo_hit;
  assign nxt_cnt = cnt_clr ? '0 :
                   i_osc_tick ? cnt_ff + togd_pkg::CNT_W'(1) : cnt_ff;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_ff <= '0;
      chip_reset_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      chip_reset_ff <= tmo_hit && !i_restart;
    end
  end

  assign o_chip_reset = chip_reset_ff;

  // ****************************************************************
  // Read back
  // ****************************************************************
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Upper bits are reserved and read as zero
  assign nxt_rdata = rd_hit ?
                     {3'h0, win_open, en_eff, sel_ff} : 8'h00;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_select_length: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    en_eff && i_osc_tick && !i_restart
    && (cnt_ff == (togd_pkg::CNT_W'(BASE_TICKS) << sel_ff)
        - togd_pkg::CNT_W'(1))
    |=> o_chip_reset && (cnt_ff == '0))
    else $error("time-out length does not follow select");

  chk_lvl0_select: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && lvl0 && wr_hit
    |=> sel_ff == $past(i_wdata[2:0]))
    else $error("level 0 select write not applied");

  chk_enable_free: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && wr_hit && i_wdata[togd_pkg::EN_BIT]
    |=> en_eff ##1 (en_eff || wr_hit || $past(wr_hit)))
    else $error("enable write not taken");

  chk_timed_disable: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && open_wr && !lvl2 ##1 !i_wr
    ##1 (wr_hit && (i_wdata[4:3] == 2'b00))
    |=> !en_eff)
    else $error("timed disable not applied");

  chk_lvl2_on: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && lvl2 && rd_hit |=> o_rdata[togd_pkg::EN_BIT])
    else $error("level 2 enable does not read one");

  chk_lvl2_select: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && lvl2 && open_wr ##1 !i_wr
    ##1 (wr_hit && !i_wdata[4])
    |=> (sel_ff == $past(i_wdata[2:0])) && en_eff)
    else $error("level 2 timed select not applied");

  chk_ce_clear: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    open_wr ##1 (!i_wr)[*4] |=> !win_open
    ##1 !o_rdata[togd_pkg::CE_BIT])
    else $error("change-enable not cleared after four cycles");

  chk_counter_clear: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (!en_eff || i_restart) |=> cnt_ff == '0)
    else $error("counter not cleared");

  chk_reset_pulse: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    o_chip_reset |=> !o_chip_reset && (cnt_ff <= 22'h000001))
    else $error("chip reset pulse wrong");

  chk_guard_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && $stable(level) && wr_hit && !win_open && !lvl0
    |=> $stable(sel_ff) && (en_eff || !$past(en_eff)))
    else $error("guarded state changed outside window");

  chk_sel_locked: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && !lvl0 && !win_open |=> $stable(sel_ff))
    else $error("select changed outside window");

  chk_enable_sticky: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && en_eff && !win_open |=> en_eff)
    else $error("guard disabled outside a window");

  chk_enable_write: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && wr_hit && i_wdata[togd_pkg::EN_BIT]
    |=> en_ff)
    else $error("enable write not stored");

  chk_lvl1_start: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && !$past(fuse_ok_ff) && !lvl2 |-> !en_eff)
    else $error("guard not disabled after reset");

  chk_lvl2_forced: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff && lvl2 |=> en_ff)
    else $error("level 2 enable register not held at one");

  chk_level_fixed: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    fuse_ok_ff |=> $stable(level) && fuse_ok_ff)
    else $error("safety level changed after fuse capture");

  // ****************************************************************
  // Checks on the window and the counter
  // ****************************************************************
  chk_window_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    open_wr ##1 (!i_wr)[*3] |=> win_open)
    else $error("change window closed too early");

  chk_window_close: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    win_open && close_wr |=> !win_open)
    else $error("change window left open after final write");

  chk_ce_visible: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    open_wr ##1 !i_wr ##1 rd_hit
    |=> o_rdata[togd_pkg::CE_BIT])
    else $error("open window does not read back");

  chk_count_step: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    en_eff && i_osc_tick && !i_restart && !tmo_hit
    |=> cnt_ff == $past(cnt_ff) + togd_pkg::CNT_W'(1))
    else $error("counter did not advance on a tick");

  chk_count_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    en_eff && !i_osc_tick && !i_restart |=> $stable(cnt_ff))
    else $error("counter moved without a tick");

  chk_restart_block: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_restart |=> !o_chip_reset)
    else $error("chip reset raised despite restart");

endmodule : togd_core

// ==== togd_pkg.sv ====
// Constants and types for the time-out guard control block.
// Assumes one system clock; the guard oscillator arrives as a tick input.
package togd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam int CE_BIT = 4;
  localparam int EN_BIT = 3;
  localparam int SEL_MSB = 2;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic EN_RESET = 1'b0;
  localparam logic CE_RESET = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CE_CYCLES = 4;
  localparam int BASE_TICKS = 16384;
  localparam int CNT_W = 22;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {LVL0, LVL1, LVL2} togd_level_type;

endpackage : togd_pkg

// ==== togd_win.sv ====
// Change-enable window: opens on a start pulse for a fixed cycle count.
// Assumes start and stop are synchronous single-cycle pulses.
`timescale 1ns/1ps
module togd_win #(
  parameter int CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_stop,
  output logic o_open
);

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  assign nxt_cnt = i_start ? 3'(CYCLES) :
                   i_stop ? 3'h0 :
                   (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
  assign o_open = (cnt_ff != 3'h0);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule : togd_win

// ==== togd_core_tb.sv ====
// Self-checking bench for the time-out guard control block.
// Assumes togd_pkg and togd_core are compiled before this file.
`timescale 1ns/1ps
module togd_core_tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_restart = 1'b0;
  logic i_osc_tick = 1'b0;
  logic i_compat_fuse = 1'b0;
  logic i_always_on_fuse = 1'b0;
  logic tick_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_chip_reset;
  int n_mismatch = 0;
  int comparisons = 0;

  always #12.5 i_clk = ~i_clk;

  // Guard oscillator: one tick every other clock while enabled
  always @(posedge i_clk) i_osc_tick <= tick_en & ~i_osc_tick;

  togd_core #(.BASE_TICKS(16)) dut (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_compat_fuse(i_compat_fuse),
    .i_always_on_fuse(i_always_on_fuse),
    .i_restart(i_restart),
    .i_osc_tick(i_osc_tick),
    .o_chip_reset(o_chip_reset)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task results;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task check(input string what, input logic [11:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Reset with fuse setting, then let the fuse capture edge pass
  task reset_dut(input logic compat, input logic always_on);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    i_compat_fuse <= compat;
    i_always_on_fuse <= always_on;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
  endtask : reset_dut

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check("control", {4'h0, o_rdata}, {4'h0, exp});
  endtask : rd

  // Restart, then count guard ticks until the chip reset pulse
  task tmo(input logic [11:0] exp);
    logic [11:0] n;
    n = 12'h000;
    @(posedge i_clk);
    tick_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
    tick_en <= 1'b1;
    repeat (4200)
    begin
      @(negedge i_clk);
      if (o_chip_reset === 1'b1)
        break;
      n = n + {11'h000, i_osc_tick};
    end
    check("ticks", n, exp);
  endtask : tmo

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    reset_dut(1'b0, 1'b0);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h08);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h0B);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    rd(8'h00, 8'h18);
    rd(8'h00, 8'h18);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    rd(8'h00, 8'h18);
    wr(8'h00, 8'h05);
    rd(8'h00, 8'h05);
    wr(8'h01, 8'h08);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h05);
    reset_dut(1'b1, 1'b0);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h0E);
    rd(8'h00, 8'h0E);
    wr(8'h00, 8'h06);
    rd(8'h00, 8'h0E);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h00, 8'h08 | s[7:0]);
      tmo(12'h010 << s);
    end
    reset_dut(1'b0, 1'b1);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h0A);
    tmo(12'h040);
    reset_dut(1'b1, 1'b1);
    rd(8'h00, 8'h08);
    results();
  end

  // Whole run needs about 8500 cycles
  initial
  begin
    #750000;
    n_mismatch++;
    results();
  end
endmodule : togd_core_tb
